// ==== verilog/frsc_pkg.sv ====
// Shared constants for the serial flash reset, unique-ID and parameter-table command logic
package frsc_pkg;
	// Command opcodes
	localparam logic [7:0] FRSC_NO_OP_CMD          = 8'h00;
	localparam logic [7:0] FRSC_RESET_ARM_CMD      = 8'h66;
	localparam logic [7:0] FRSC_RESET_CMD          = 8'h99;
	localparam logic [7:0] FRSC_UNIQUE_ID_READ_CMD = 8'h4B;
	localparam logic [7:0] FRSC_PARAM_TABLE_READ_CMD = 8'h5A;
	// Frame layout in bytes; ID length in bits
	localparam int FRSC_UID_DUMMY_BYTES   = 4;
	localparam int FRSC_TABLE_ADDR_BYTES  = 3;
	localparam int FRSC_TABLE_DUMMY_BYTES = 1;
	localparam int FRSC_UID_BITS          = 128;
	// Table contents
	localparam logic [31:0] FRSC_SIGNATURE     = 32'h5044_4653;
	localparam logic [7:0]  FRSC_REV_MINOR     = 8'h00;
	localparam logic [7:0]  FRSC_REV_MAJOR     = 8'h01;
	localparam logic [7:0]  FRSC_HEADER_COUNT  = 8'h01;
	localparam logic [7:0]  FRSC_UNUSED_BYTE   = 8'hFF;
	localparam logic [7:0]  FRSC_STD_ID        = 8'h00;
	localparam logic [7:0]  FRSC_STD_LEN       = 8'h09;
	localparam logic [7:0]  FRSC_STD_TABLE_POINTER = 8'h30;
	localparam logic [7:0]  FRSC_VND_LEN       = 8'h03;
	localparam logic [7:0]  FRSC_VND_TABLE_POINTER = 8'h90;
	localparam logic [7:0]  FRSC_PTR_UPPER     = 8'h00;
	// Reset recovery time and its count at 100 MHz
	localparam int FRSC_CLK_MHZ          = 100;
	localparam int FRSC_RECOVERY_US      = 12;
	localparam int FRSC_RECOVERY_CYCLES  = FRSC_RECOVERY_US * FRSC_CLK_MHZ;
	// Link clock divider for the host end: half period in system clocks
	localparam int FRSC_SCK_HALF         = 8;
endpackage

// ==== verilog/frsc_if.sv ====
// Serial bus between flash controller and flash command logic
`timescale 1ns/10ps
interface frsc_if;
	logic       cs_n;
	logic       sck;
	logic       si;
	logic [2:0] upper_io_lines;
	logic       so;
	logic       so_oe;
	modport host (output cs_n, output sck, output si, output upper_io_lines,
		input so, input so_oe);
	modport dev (input cs_n, input sck, input si, input upper_io_lines,
		output so, output so_oe);
endinterface

// ==== verilog/frsc_fifo.sv ====
// Small flip-flop FIFO with valid/ready on both sides
`timescale 1ns/10ps
module frsc_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic             sys_clk,
	input  wire logic             rst,
	// Fill side
	input  wire logic [WIDTH-1:0] in_data,
	input  wire logic             in_valid,
	output logic                  in_ready,
	// Drain side
	output logic [WIDTH-1:0]      out_data,
	output logic                  out_valid,
	input  wire logic             out_ready
);
	localparam int AW = $clog2(DEPTH);
	// Refuse depths the wrap-bit pointers cannot serve
	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("DEPTH must be a power of two");
	end
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW:0]      wr_ptr;
	logic [AW:0]      rd_ptr;
	logic             push;
	logic             pop;
	// Full and empty from pointer wrap bits
	assign in_ready  = (wr_ptr[AW] == rd_ptr[AW]) || (wr_ptr[AW-1:0] != rd_ptr[AW-1:0]);
	assign out_valid = (wr_ptr != rd_ptr);
	assign out_data  = mem[rd_ptr[AW-1:0]];
	assign push      = in_valid && in_ready;
	assign pop       = out_valid && out_ready;
	// Storage
	always_ff @(posedge sys_clk) begin
		if (push) begin
			mem[wr_ptr[AW-1:0]] <= in_data;
		end
	end
	// Pointers
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
		end else begin
			if (push) begin
				wr_ptr <= wr_ptr + 1'b1;
			end
			if (pop) begin
				rd_ptr <= rd_ptr + 1'b1;
			end
		end
	end
endmodule // frsc_fifo

// ==== verilog/frsc_dev.sv ====
// Flash end: no-op, two-step software reset, unique-ID read, parameter-table read
// Overview of operation
// - No-op only cancels an armed reset
// - Reset group commands use only primary input
// - Software reset restores power-on defaults, standby
// - Reset acts only right after reset-arm
// - Any other command disarms a pending reset
// - Reset aborts a running program or erase
// - Fixed read-only 128-bit unique identifier
// - ID read: opcode, four dummies, ID out
// - Table read: opcode, three address, one dummy
// - Chip select high ends table read output
// - Only low address byte indexes the table
// - Signature low byte first, revision 1.0
// - Header count 01H at location 06H
// - Locations 07H, 0FH, 17H read FFH
// - First header: ID 00, 1.0, 9 dwords, 30H
// - Second header: maker, 1.0, 3 dwords, 90H
// - Reset commands accepted while suspended
`timescale 1ns/10ps
module frsc_dev
	import frsc_pkg::*;
#(
	parameter logic [127:0] UNIQUE_ID   = 128'h0123_4567_89AB_CDEF_0F1E_2D3C_4B5A_6978,
	parameter logic [7:0]   MAKER_CODE  = 8'h5C, // Arbitrary value
	parameter int           RECOVERY    = FRSC_RECOVERY_CYCLES
) (
	// Clock and reset
	input  wire logic sys_clk,
	input  wire logic rst,
	// Serial bus
	frsc_if.dev       bus,
	// Array engine status and abort
	input  wire logic busy,
	input  wire logic suspended,
	output logic      abort_op,
	output logic      sw_reset,
	output logic      in_recovery
);
	// Refuse a recovery interval the counter cannot serve
	if (RECOVERY < 1) begin : g_bad_recovery
		$error("RECOVERY must be at least one cycle");
	end
	typedef enum logic [2:0] {
		FRSC_S_CMD   = 3'b000,
		FRSC_S_ADDR  = 3'b001,
		FRSC_S_DUMMY = 3'b010,
		FRSC_S_OUT   = 3'b011,
		FRSC_S_SKIP  = 3'b100
	} frsc_dev_state_t;
	frsc_dev_state_t state;
	logic [1:0]  cs_sync;
	logic [2:0]  sck_sync;
	logic [1:0]  si_sync;
	logic        cs_act;
	logic        rise;
	logic        fall;
	logic [7:0]  shreg;
	logic [5:0]  bit_cnt;
	logic [7:0]  addr;
	logic        uid_mode;
	logic [6:0]  uid_idx;
	logic [2:0]  out_bit;
	logic        armed;
	logic [$clog2(RECOVERY+1)-1:0] rec_cnt;
	logic [7:0]  cur_byte;
	logic [7:0]  next_shreg;
	// Inputs from the link pass two flops; edges compare the second and third
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cs_sync  <= 2'b11;
			sck_sync <= 3'b000;
			si_sync  <= 2'b00;
		end else begin
			cs_sync  <= {cs_sync[0], bus.cs_n};
			sck_sync <= {sck_sync[1:0], bus.sck};
			si_sync  <= {si_sync[0], bus.si};
		end
	end
	assign cs_act     = !cs_sync[1];
	assign rise       = cs_act && sck_sync[1] && !sck_sync[2];
	assign fall       = cs_act && !sck_sync[1] && sck_sync[2];
	assign next_shreg = {shreg[6:0], si_sync[1]};
	// Table contents decoded from the low address byte only
	always_comb begin
		case (addr)
			8'h00: cur_byte = FRSC_SIGNATURE[7:0];
			8'h01: cur_byte = FRSC_SIGNATURE[15:8];
			8'h02: cur_byte = FRSC_SIGNATURE[23:16];
			8'h03: cur_byte = FRSC_SIGNATURE[31:24];
			8'h04: cur_byte = FRSC_REV_MINOR;
			8'h05: cur_byte = FRSC_REV_MAJOR;
			8'h06: cur_byte = FRSC_HEADER_COUNT;
			8'h08: cur_byte = FRSC_STD_ID;
			8'h09: cur_byte = FRSC_REV_MINOR;
			8'h0A: cur_byte = FRSC_REV_MAJOR;
			8'h0B: cur_byte = FRSC_STD_LEN;
			8'h0C: cur_byte = FRSC_STD_TABLE_POINTER;
			8'h0D: cur_byte = FRSC_PTR_UPPER;
			8'h0E: cur_byte = FRSC_PTR_UPPER;
			8'h10: cur_byte = MAKER_CODE;
			8'h11: cur_byte = FRSC_REV_MINOR;
			8'h12: cur_byte = FRSC_REV_MAJOR;
			8'h13: cur_byte = FRSC_VND_LEN;
			8'h14: cur_byte = FRSC_VND_TABLE_POINTER;
			8'h15: cur_byte = FRSC_PTR_UPPER;
			8'h16: cur_byte = FRSC_PTR_UPPER;
			default: cur_byte = FRSC_UNUSED_BYTE;
		endcase
	end
	// Command, address and dummy phases, and output stepping
	always_ff @(posedge sys_clk) begin
		if (rst || sw_reset || !cs_act) begin
			state    <= FRSC_S_CMD;
			bit_cnt  <= '0;
			shreg    <= '0;
			if (rst || sw_reset) begin
				addr     <= '0;
				uid_mode <= 1'b0;
			end
			uid_idx  <= '0;
			out_bit  <= '0;
		end else if (rise) begin
			shreg <= next_shreg;
			bit_cnt <= bit_cnt + 6'd1;
			case (state)
				FRSC_S_CMD: begin
					if (bit_cnt == 6'd7) begin
						bit_cnt <= '0;
						if (in_recovery) begin
							state <= FRSC_S_SKIP;
						end else if (next_shreg == FRSC_UNIQUE_ID_READ_CMD) begin
							state    <= FRSC_S_DUMMY;
							uid_mode <= 1'b1;
						end else if (next_shreg == FRSC_PARAM_TABLE_READ_CMD) begin
							state    <= FRSC_S_ADDR;
							uid_mode <= 1'b0;
						end else begin
							state <= FRSC_S_SKIP;
						end
					end
				end
				FRSC_S_ADDR: begin
					if (bit_cnt == 6'(8 * FRSC_TABLE_ADDR_BYTES - 1)) begin
						bit_cnt <= '0;
						addr    <= next_shreg;
						state   <= FRSC_S_DUMMY;
					end
				end
				FRSC_S_DUMMY: begin
					if ((uid_mode && bit_cnt == 6'(8 * FRSC_UID_DUMMY_BYTES - 1)) ||
						(!uid_mode && bit_cnt == 6'(8 * FRSC_TABLE_DUMMY_BYTES - 1))) begin
						bit_cnt <= '0;
						state   <= FRSC_S_OUT;
					end
				end
				FRSC_S_OUT: begin
					bit_cnt <= 6'd1; // Host has sampled a data bit
				end
				FRSC_S_SKIP: begin
					bit_cnt <= '0;
				end
				default: state <= FRSC_S_CMD;
			endcase
		end else if (fall && state == FRSC_S_OUT && bit_cnt != '0) begin
			// Step only once a data bit was sampled; the last dummy fall must not step
			if (uid_mode) begin
				uid_idx <= uid_idx + 7'd1;
			end else begin
				out_bit <= out_bit + 3'd1;
				if (out_bit == 3'd7) begin
					addr <= addr + 8'd1;
				end
			end
		end
	end
	// Serial output; driven only while selected in the output phase
	always_ff @(posedge sys_clk) begin
		if (rst || !cs_act || state != FRSC_S_OUT) begin
			bus.so    <= 1'b0;
			bus.so_oe <= 1'b0;
		end else begin
			bus.so_oe <= 1'b1;
			bus.so    <= uid_mode ? UNIQUE_ID[7'd127 - uid_idx]
				: cur_byte[3'd7 - out_bit];
		end
	end
	// Reset arm: set by reset-arm, cleared by any other completed command
	always_ff @(posedge sys_clk) begin
		if (rst || sw_reset) begin
			armed    <= 1'b0;
			sw_reset <= 1'b0;
			abort_op <= 1'b0;
		end else begin
			sw_reset <= 1'b0;
			abort_op <= 1'b0;
			if (rise && state == FRSC_S_CMD && bit_cnt == 6'd7 && !in_recovery) begin
				if (next_shreg == FRSC_RESET_ARM_CMD) begin
					armed <= 1'b1;
				end else if (next_shreg == FRSC_RESET_CMD && armed) begin
					armed    <= 1'b0;
					sw_reset <= 1'b1;
					abort_op <= busy || suspended;
				end else begin
					armed <= 1'b0;
				end
			end
		end
	end
	// Recovery interval after a software reset
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			rec_cnt     <= '0;
			in_recovery <= 1'b0;
		end else if (sw_reset) begin
			rec_cnt     <= ($clog2(RECOVERY+1))'(RECOVERY);
			in_recovery <= 1'b1;
		end else if (rec_cnt != '0) begin
			rec_cnt     <= rec_cnt - 1'b1;
			in_recovery <= (rec_cnt != 1);
		end
	end
endmodule // frsc_dev

// ==== verilog/frsc_host.sv ====
// Controller end: issues framed commands and collects returned bytes into a FIFO
`timescale 1ns/10ps
module frsc_host
	import frsc_pkg::*;
#(
	parameter int DEPTH = 16
) (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        rst,
	// Request: opcode, 24-bit address, number of bytes to read
	input  wire logic        req_valid,
	input  wire logic [7:0]  req_cmd,
	input  wire logic [23:0] req_addr,
	input  wire logic [7:0]  req_len,
	output logic             req_ready,
	// Returned data
	output logic [7:0]       rd_data,
	output logic             rd_valid,
	input  wire logic        rd_ready,
	// Serial bus
	frsc_if.host             bus
);
	typedef enum logic [1:0] {
		FRSC_H_IDLE = 2'b00,
		FRSC_H_SEND = 2'b01,
		FRSC_H_READ = 2'b10,
		FRSC_H_END  = 2'b11
	} frsc_host_state_t;
	frsc_host_state_t state;
	logic [63:0] tx;
	logic [6:0]  tx_bits;
	logic [7:0]  bytes_left;
	logic [2:0]  rx_bits;
	logic [7:0]  rx;
	logic [3:0]  div;
	logic        push;
	logic        fifo_ready;
	logic [1:0]  so_sync;
	// Divided serial clock ticks
	wire tick = (div == 4'(FRSC_SCK_HALF - 1));
	// Device output passes two flops
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			so_sync <= 2'b00;
		end else begin
			so_sync <= {so_sync[0], bus.so};
		end
	end
	// Frame sequencer; reads stall while the FIFO is full
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state      <= FRSC_H_IDLE;
			bus.cs_n   <= 1'b1;
			bus.sck    <= 1'b0;
			bus.si     <= 1'b0;
			tx         <= '0;
			tx_bits    <= '0;
			bytes_left <= '0;
			rx_bits    <= '0;
			rx         <= '0;
			div        <= '0;
			push       <= 1'b0;
			req_ready  <= 1'b0;
		end else begin
			push      <= 1'b0;
			req_ready <= (state == FRSC_H_IDLE) && !req_valid;
			div       <= tick ? 4'd0 : div + 4'd1;
			case (state)
				FRSC_H_IDLE: begin
					div <= '0;
					if (req_valid && req_ready) begin
						bus.cs_n   <= 1'b0;
						bytes_left <= req_len;
						state      <= FRSC_H_SEND;
						if (req_cmd == FRSC_PARAM_TABLE_READ_CMD) begin
							tx <= {req_cmd, req_addr, 8'h00, 24'h000000};
							tx_bits <= 7'd40;
						end else if (req_cmd == FRSC_UNIQUE_ID_READ_CMD) begin
							tx <= {req_cmd, 32'h0000_0000, 24'h000000};
							tx_bits <= 7'd40;
						end else begin
							tx <= {req_cmd, 56'h0};
							tx_bits <= 7'd8;
						end
						bus.si <= req_cmd[7];
					end
				end
				FRSC_H_SEND: begin
					if (tick) begin
						bus.sck <= !bus.sck;
						if (bus.sck) begin
							tx      <= {tx[62:0], 1'b0};
							bus.si  <= tx[62];
							tx_bits <= tx_bits - 7'd1;
							if (tx_bits == 7'd1) begin
								state <= (bytes_left == 0) ? FRSC_H_END : FRSC_H_READ;
							end
						end
					end
				end
				FRSC_H_READ: begin
					if (tick && (bus.sck || fifo_ready)) begin
						bus.sck <= !bus.sck;
						if (!bus.sck) begin
							rx      <= {rx[6:0], so_sync[1]};
							rx_bits <= rx_bits + 3'd1;
							if (rx_bits == 3'd7) begin
								push       <= 1'b1;
								bytes_left <= bytes_left - 8'd1;
								if (bytes_left == 8'd1) begin
									state <= FRSC_H_END;
								end
							end
						end
					end
				end
				FRSC_H_END: begin
					if (tick) begin
						bus.sck  <= 1'b0;
						bus.cs_n <= 1'b1;
						rx_bits  <= '0;
						state    <= FRSC_H_IDLE;
					end
				end
				default: state <= FRSC_H_IDLE;
			endcase
		end
	end
	assign bus.upper_io_lines = 3'b000;
	// FIFO holds finished bytes; its ready stalls the serial clock
	frsc_fifo #(.WIDTH(8), .DEPTH(DEPTH)) u_rx_fifo (
		.sys_clk   (sys_clk),
		.rst       (rst),
		.in_data   (rx),
		.in_valid  (push),
		.in_ready  (fifo_ready),
		.out_data  (rd_data),
		.out_valid (rd_valid),
		.out_ready (rd_ready)
	);
endmodule // frsc_host

// ==== sim/frsc_props.sv ====
// Concurrent checks on the serial link and the reset outputs of the flash end
`timescale 1ns/10ps
module frsc_props #(
	parameter int RECOVERY = 20
) (
	// Clock and reset
	input  wire logic       sys_clk,
	input  wire logic       rst,
	// Serial bus
	input  wire logic       cs_n,
	input  wire logic       sck,
	input  wire logic [2:0] upper_io_lines,
	input  wire logic       so_oe,
	// Device status
	input  wire logic       busy,
	input  wire logic       suspended,
	input  wire logic       abort_op,
	input  wire logic       sw_reset,
	input  wire logic       in_recovery
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Length of the current recovery run
	int unsigned rec_run;
	always_ff @(posedge sys_clk) begin
		if (rst || !in_recovery)
			rec_run <= 0;
		else
			rec_run <= rec_run + 1;
	end

	a_abort_with_reset: assert property (abort_op |-> sw_reset)
		else $error("abort without software reset");
	a_abort_on_busy: assert property (sw_reset && (busy || suspended)
		&& ($past(busy) || $past(suspended)) |-> abort_op)
		else $error("reset did not abort array work");
	a_no_abort_idle: assert property (sw_reset && !busy && !suspended
		&& !$past(busy) && !$past(suspended) |-> !abort_op)
		else $error("abort while array idle");
	a_reset_single_pulse: assert property (sw_reset |=> !sw_reset)
		else $error("reset pulse too long");
	a_recovery_starts: assert property (sw_reset |=> in_recovery)
		else $error("no recovery after reset");
	a_recovery_length: assert property ($fell(in_recovery) |-> rec_run == RECOVERY)
		else $error("recovery length wrong");
	a_recovery_bounded: assert property (in_recovery |-> rec_run < RECOVERY)
		else $error("recovery overran");
	a_no_reset_recovering: assert property (in_recovery && $past(in_recovery) |-> !sw_reset)
		else $error("reset taken during recovery");
	a_oe_off_deselected: assert property (cs_n [*5] |-> !so_oe)
		else $error("output driven while deselected");
	a_oe_only_selected: assert property ($rose(so_oe) |-> !cs_n)
		else $error("output enabled without select");
	a_upper_lines_quiet: assert property (!cs_n |-> upper_io_lines == 3'h0)
		else $error("upper lines not held low");
	a_sck_low_idle: assert property (cs_n |-> !sck)
		else $error("serial clock active while deselected");

	// Main scenarios reached
	c_reset: cover property (sw_reset);
	c_abort: cover property (abort_op);
	c_read_end: cover property ($fell(so_oe));
endmodule // frsc_props

// ==== sim/tb_flash_reset_uid_sfdp_cmds.sv ====
// Testbench joining the controller end and the flash end over the serial bus
`timescale 1ns/10ps
module tb_flash_reset_uid_sfdp_cmds;
	import frsc_pkg::*;
	localparam logic [127:0] UID   = 128'h1F2E_3D4C_5B6A_7988_9701_A2B3_C4D5_E6F7;
	localparam logic [7:0]   MAKER = 8'hA7; // Arbitrary value
	localparam int           RECOV = 600;
	localparam int           LIMIT = 60000;
	// Design signals
	logic        sys_clk;
	logic        rst;
	logic        req_valid;
	logic [7:0]  req_cmd;
	logic [23:0] req_addr;
	logic [7:0]  req_len;
	logic        req_ready;
	logic [7:0]  rd_data;
	logic        rd_valid;
	logic        rd_ready;
	logic        busy;
	logic        suspended;
	logic        abort_op;
	logic        sw_reset;
	logic        in_recovery;
	// Bookkeeping
	int          miscompares;
	int          n_compared;
	int          n_rst;
	int          n_abort;
	int          cycles;
	logic [7:0]  rx[$];
	logic [7:0]  tbl [24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF,
		8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
		MAKER, 8'h00, 8'h01, 8'h03, 8'h90, 8'h00, 8'h00, 8'hFF};

	frsc_if bus_if ();
	frsc_host #(.DEPTH(16)) i_frsc_host (.sys_clk(sys_clk), .rst(rst), .req_valid(req_valid),
		.req_cmd(req_cmd), .req_addr(req_addr), .req_len(req_len), .req_ready(req_ready),
		.rd_data(rd_data), .rd_valid(rd_valid), .rd_ready(rd_ready), .bus(bus_if.host));
	frsc_dev #(.UNIQUE_ID(UID), .MAKER_CODE(MAKER), .RECOVERY(RECOV)) i_frsc_dev (
		.sys_clk(sys_clk), .rst(rst), .bus(bus_if.dev), .busy(busy), .suspended(suspended),
		.abort_op(abort_op), .sw_reset(sw_reset), .in_recovery(in_recovery));
	frsc_props #(.RECOVERY(RECOV)) i_frsc_props (.sys_clk(sys_clk), .rst(rst),
		.cs_n(bus_if.cs_n), .sck(bus_if.sck), .upper_io_lines(bus_if.upper_io_lines),
		.so_oe(bus_if.so_oe), .busy(busy), .suspended(suspended), .abort_op(abort_op),
		.sw_reset(sw_reset), .in_recovery(in_recovery));

	// Clock
	initial begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end

	// Collect bytes, count reset pulses, cut hangs short
	always @(posedge sys_clk) begin
		if (rd_valid === 1'b1 && rd_ready === 1'b1)
			rx.push_back(rd_data);
		if (rst === 1'b0 && sw_reset === 1'b1)
			n_rst++;
		if (rst === 1'b0 && abort_op === 1'b1)
			n_abort++;
		cycles++;
		if (cycles == LIMIT) begin
			miscompares++;
			results();
		end
	end

	task automatic check(input logic [127:0] seen, input logic [127:0] exp);
		n_compared++;
		if (seen !== exp) begin
			miscompares++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	// One framed command; returns once the frame is over
	task automatic xfer(input logic [7:0] op, input logic [23:0] a, input logic [7:0] n);
		rx.delete();
		@(posedge sys_clk);
		#1;
		req_valid = 1'b1;
		req_cmd = op;
		req_addr = a;
		req_len = n;
		do
			@(posedge sys_clk);
		while (req_ready !== 1'b1);
		#1;
		req_valid = 1'b0;
		while (bus_if.cs_n === 1'b1)
			@(posedge sys_clk);
		while (bus_if.cs_n !== 1'b1)
			@(posedge sys_clk);
		repeat (24) @(posedge sys_clk);
		#1;
	endtask

	task automatic check_tbl(input int first, input int n);
		check(rx.size(), n);
		for (int i = 0; i < n; i++)
			check(rx[i], tbl[first + i]);
	endtask

	// Three frames that read no bytes, then count reset and abort pulses
	task automatic try_reset(input logic [7:0] op0, input logic [7:0] op1,
		input logic [7:0] op2, input int exp_rst, input int exp_abort);
		int r0;
		int a0;
		r0 = n_rst;
		a0 = n_abort;
		xfer(op0, 24'h00_0000, 8'h00);
		xfer(op1, 24'h00_0000, 8'h00);
		xfer(op2, 24'h00_0000, 8'h00);
		check(n_rst - r0, exp_rst);
		check(n_abort - a0, exp_abort);
	endtask

	task automatic results();
		if (miscompares == 0 && n_compared > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Main sequence
	initial begin
		rst = 1'b1;
		req_valid = 1'b0;
		req_cmd = 8'h00;
		req_addr = 24'h00_0000;
		req_len = 8'h00;
		rd_ready = 1'b1;
		busy = 1'b0;
		suspended = 1'b0;
		repeat (3) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		// Table reads, the first two with upper address bytes set
		xfer(8'h5A, 24'hA5_5A00, 8'h10);
		check_tbl(0, 16);
		xfer(8'h5A, 24'hFF_0010, 8'h08);
		check_tbl(16, 8);
		xfer(8'h5A, 24'h00_0006, 8'h02);
		check_tbl(6, 2);
		// ID read with the far side stalled until the buffer is full
		rd_ready = 1'b0;
		xfer(8'h4B, 24'h00_0000, 8'h10);
		check(rd_valid, 1'b1);
		check(rx.size(), 0);
		rd_ready = 1'b1;
		repeat (24) @(posedge sys_clk);
		check(rx.size(), 16);
		for (int i = 0; i < 16; i++)
			check(rx[i], UID[127 - 8 * i -: 8]);
		// Reset sequences
		try_reset(8'h66, 8'h00, 8'h99, 0, 0);
		try_reset(8'h66, 8'h5A, 8'h99, 0, 0);
		try_reset(8'h00, 8'h00, 8'h99, 0, 0);
		xfer(8'h5A, 24'h00_0000, 8'h04);
		check_tbl(0, 4);
		try_reset(8'h00, 8'h66, 8'h99, 1, 0);
		try_reset(8'h00, 8'h66, 8'h99, 0, 0);
		while (in_recovery === 1'b1) @(posedge sys_clk);
		#1;
		try_reset(8'h00, 8'h00, 8'h99, 0, 0);
		busy = 1'b1;
		try_reset(8'h00, 8'h66, 8'h99, 1, 1);
		busy = 1'b0;
		while (in_recovery === 1'b1) @(posedge sys_clk);
		#1;
		suspended = 1'b1;
		try_reset(8'h00, 8'h66, 8'h99, 1, 1);
		suspended = 1'b0;
		while (in_recovery === 1'b1) @(posedge sys_clk);
		xfer(8'h4B, 24'h00_0000, 8'h10);
		check(rx[15], UID[7:0]);
		results();
	end
endmodule // tb_flash_reset_uid_sfdp_cmds
